// ===== design/ufi_pkg.sv
// Constants for the USB power, frame and event-flag register block
package ufi_pkg;
    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [5:0] IDX_POWER   = 6'h01;
    localparam logic [5:0] IDX_IN_FL   = 6'h02;
    localparam logic [5:0] IDX_OUT_FL  = 6'h04;
    localparam logic [5:0] IDX_CM_FL   = 6'h06;
    localparam logic [5:0] IDX_IN_EN   = 6'h07;
    localparam logic [5:0] IDX_OUT_EN  = 6'h09;
    localparam logic [5:0] IDX_CM_EN   = 6'h0b;
    localparam logic [5:0] IDX_FRAME_L = 6'h0c;
    localparam logic [5:0] IDX_FRAME_H = 6'h0d;
    // ------------------------------------------------------------
    // Power register fields
    // ------------------------------------------------------------
    localparam int PWR_ISO_DEFER  = 7;
    localparam int PWR_INHIBIT    = 4;
    localparam int PWR_RESET      = 3;
    localparam int PWR_RESUME     = 2;
    localparam int PWR_SUSPENDED  = 1;
    localparam int PWR_SUSP_EN    = 0;
    // ------------------------------------------------------------
    // Common flag fields and frame high bit offset
    // ------------------------------------------------------------
    localparam int CM_SOF         = 3;
    localparam int CM_BUS_RESET   = 2;
    localparam int CM_WAKEUP      = 1;
    localparam int CM_SLEEP       = 0;
    localparam int FRAME_HI_LSB   = 8;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] POWER_RST  = 8'h10;
    localparam logic [1:0] IN_EN_RST  = 2'h3;
    localparam logic       OUT_EN_RST = 1'b1;
    localparam logic [3:0] CM_EN_RST  = 4'h6;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int FRAME_NS     = 1000000;
    localparam int CLK_NS       = 100;
    localparam int FRAME_CYCLES = FRAME_NS / CLK_NS;
    localparam int FRAME_GUARD  = 50;
endpackage

// ===== design/ufi_regs.sv
// USB power control, frame number and event-flag registers behind APB
//
// Behaviour
// - Iso update off: send ready packet next IN
// - Iso update on: hold until SOF, else zero-length
// - Inhibit reads one after hardware or soft reset, not after bus reset
// - Software write of one to inhibit ignored
// - Inhibit set ignores all bus traffic
// - Writing reset bit resets whole controller
// - Reset bit reads live bus reset detect
// - Resume write while suspended drives wakeup signalling
// - Resume cleared: leave suspend, raise interrupt
// - Suspend state set on suspend, cleared on resume
// - Suspend enable gates suspend detection
// - Frame low returns frame bits 7-0
// - Frame high returns bits 10-8, rest zero
// - Interrupt request high while any flag set
// - Reading flag register clears only that register
// - IN flags: control bit0, IN one bit1
// - OUT flags: OUT one in bit1 only
// - SOF flag on token or missed SOF
// - Bus reset flag on reset signalling
// - Wakeup flag on resume while suspended
// - Sleep flag only with suspend detect enabled
// - Enables per flag, common resets to 06
// - Leave suspend on resume, bus reset, reset
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
module ufi_regs #(
    parameter int unsigned TW           = 16,
    parameter int unsigned FRAME_CYCLES = ufi_pkg::FRAME_CYCLES,
    parameter int unsigned FRAME_GUARD  = ufi_pkg::FRAME_GUARD
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        sie_sof_token,
    input  wire logic [10:0] sie_frame_number,
    input  wire logic        sie_bus_reset,
    input  wire logic        sie_resume_detect,
    input  wire logic        sie_suspend_detect,
    input  wire logic        sie_ep0_event,
    input  wire logic        sie_in1_event,
    input  wire logic        sie_out_ep_one_pending_event,
    input  wire logic        iso_in_token,
    input  wire logic        in_packet_ready,
    output logic             usb_irq,
    output logic             controller_inhibit,
    output logic             core_reset,
    output logic             drive_resume,
    output logic             suspend_state,
    output logic             iso_send_packet,
    output logic             iso_send_zero_length
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0]    rdata;
        logic          slverr;
        logic          iso_deferred_send;
        logic          controller_inhibit;
        logic          resume;
        logic          suspend_state;
        logic          suspend_detect_enable;
        logic [10:0]   frame;
        logic [1:0]    in_fl;
        logic          out_fl;
        logic [3:0]    cm_fl;
        logic [1:0]    in_en;
        logic          out_en;
        logic [3:0]    cm_en;
        logic          bus_rst_prev;
        logic          core_rst;
        logic          sof_seen;
        logic [TW-1:0] timer;
        logic          iso_pkt;
        logic          iso_rel;
        logic          iso_send;
        logic          iso_zlp;
    } ufi_state_t;

    ufi_state_t s_q;
    ufi_state_t s_d;

    function automatic ufi_state_t ufi_reset_state();
        ufi_state_t r;
        r                       = '0;
        r.controller_inhibit    = ufi_pkg::POWER_RST[ufi_pkg::PWR_INHIBIT];
        r.iso_deferred_send     = ufi_pkg::POWER_RST[ufi_pkg::PWR_ISO_DEFER];
        r.suspend_detect_enable = ufi_pkg::POWER_RST[ufi_pkg::PWR_SUSP_EN];
        r.in_en                 = ufi_pkg::IN_EN_RST;
        r.out_en                = ufi_pkg::OUT_EN_RST;
        r.cm_en                 = ufi_pkg::CM_EN_RST;
        return r;
    endfunction

    function automatic logic [7:0] ufi_read(input logic [5:0] idx, input ufi_state_t s,
                                            input logic bus_rst);
        logic [7:0] v;
        v = 8'h00;
        case (idx)
            ufi_pkg::IDX_POWER: begin
                v[ufi_pkg::PWR_ISO_DEFER] = s.iso_deferred_send;
                v[ufi_pkg::PWR_INHIBIT]   = s.controller_inhibit;
                v[ufi_pkg::PWR_RESET]     = bus_rst;
                v[ufi_pkg::PWR_RESUME]    = s.resume;
                v[ufi_pkg::PWR_SUSPENDED] = s.suspend_state;
                v[ufi_pkg::PWR_SUSP_EN]   = s.suspend_detect_enable;
            end
            ufi_pkg::IDX_IN_FL:   v[1:0] = s.in_fl;
            ufi_pkg::IDX_OUT_FL:  v[1]   = s.out_fl;
            ufi_pkg::IDX_CM_FL:   v[3:0] = s.cm_fl;
            ufi_pkg::IDX_IN_EN:   v[1:0] = s.in_en;
            ufi_pkg::IDX_OUT_EN:  v[1]   = s.out_en;
            ufi_pkg::IDX_CM_EN:   v[3:0] = s.cm_en;
            ufi_pkg::IDX_FRAME_L: v      = s.frame[7:0];
            ufi_pkg::IDX_FRAME_H: v[2:0] = s.frame[10:ufi_pkg::FRAME_HI_LSB];
            default:              v      = 8'h00;
        endcase
        return v;
    endfunction

    function automatic logic ufi_mapped(input logic [5:0] idx);
        return idx == ufi_pkg::IDX_POWER || idx == ufi_pkg::IDX_IN_FL
            || idx == ufi_pkg::IDX_OUT_FL || idx == ufi_pkg::IDX_CM_FL
            || idx == ufi_pkg::IDX_IN_EN || idx == ufi_pkg::IDX_OUT_EN
            || idx == ufi_pkg::IDX_CM_EN || idx == ufi_pkg::IDX_FRAME_L
            || idx == ufi_pkg::IDX_FRAME_H;
    endfunction

    // ------------------------------------------------------------
    // Bus decode and events
    // ------------------------------------------------------------
    logic [5:0] idx;
    logic       setup;
    logic       wr_acc;
    logic       rd_acc;
    logic       wr_power;
    logic       ok;
    logic       rst_rise;
    logic       timer_exp;
    logic       sof_evt;
    logic       resume_end;
    logic       wake_det;
    logic       sleep_det;
    logic [1:0] in_set;
    logic       out_set;
    logic [3:0] cm_set;

    assign idx       = paddr[7:2];
    assign setup     = psel & ~penable;
    assign wr_acc    = psel & penable & pwrite;
    assign rd_acc    = psel & penable & ~pwrite;
    assign wr_power  = wr_acc && idx == ufi_pkg::IDX_POWER;
    assign ok        = ~s_q.controller_inhibit;
    assign rst_rise  = ok & sie_bus_reset & ~s_q.bus_rst_prev;
    // Only armed once a real SOF has set the frame phase
    assign timer_exp = ok & s_q.sof_seen & ~sie_sof_token
                     & (s_q.timer == TW'(FRAME_CYCLES + FRAME_GUARD - 1));
    assign sof_evt   = (ok & sie_sof_token) | timer_exp;
    assign resume_end = wr_power & ~pwdata[ufi_pkg::PWR_RESUME]
                      & ~pwdata[ufi_pkg::PWR_RESET] & s_q.resume;
    assign wake_det  = ok & sie_resume_detect & s_q.suspend_state;
    assign sleep_det = ok & sie_suspend_detect & s_q.suspend_detect_enable;

    // Flags only latch events whose enable is set
    assign in_set  = {sie_in1_event, sie_ep0_event} & {2{ok}} & s_q.in_en;
    assign out_set = sie_out_ep_one_pending_event & ok & s_q.out_en;
    assign cm_set  = {sof_evt, rst_rise, wake_det | resume_end, sleep_det}
                   & s_q.cm_en;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_d              = s_q;
        s_d.core_rst     = 1'b0;
        s_d.iso_send     = 1'b0;
        s_d.iso_zlp      = 1'b0;
        s_d.bus_rst_prev = sie_bus_reset;

        // Read data is captured in setup so prdata comes from a flop
        if (setup) begin
            s_d.rdata  = ufi_read(idx, s_q, sie_bus_reset);
            s_d.slverr = ~ufi_mapped(idx);
        end

        // Only bits actually returned are cleared, so a late set survives
        s_d.in_fl  = s_q.in_fl;
        s_d.out_fl = s_q.out_fl;
        s_d.cm_fl  = s_q.cm_fl;
        if (rd_acc && idx == ufi_pkg::IDX_IN_FL) begin
            s_d.in_fl = s_q.in_fl & ~s_q.rdata[1:0];
        end
        if (rd_acc && idx == ufi_pkg::IDX_OUT_FL) begin
            s_d.out_fl = s_q.out_fl & ~s_q.rdata[1];
        end
        if (rd_acc && idx == ufi_pkg::IDX_CM_FL) begin
            s_d.cm_fl = s_q.cm_fl & ~s_q.rdata[3:0];
        end
        s_d.in_fl  = s_d.in_fl | in_set;
        s_d.out_fl = s_d.out_fl | out_set;
        s_d.cm_fl  = s_d.cm_fl | cm_set;

        if (ok && sie_sof_token) begin
            s_d.frame = sie_frame_number;
        end

        // Frame interval timer
        if (ok && sie_sof_token) begin
            s_d.sof_seen = 1'b1;
            s_d.timer    = '0;
        end else if (timer_exp) begin
            s_d.timer = '0;
        end else if (s_q.sof_seen) begin
            s_d.timer = s_q.timer + TW'(1);
        end
        if (rst_rise || s_q.suspend_state || !ok) begin
            s_d.sof_seen = 1'b0;
            s_d.timer    = '0;
        end

        // Suspend state
        if (sleep_det) begin
            s_d.suspend_state = 1'b1;
        end
        if (wake_det || rst_rise || resume_end || (ok && sie_resume_detect)) begin
            s_d.suspend_state = 1'b0;
        end

        // Isochronous IN release
        if (in_packet_ready) begin
            s_d.iso_pkt = 1'b1;
            s_d.iso_rel = 1'b0;
        end
        if (sof_evt && s_q.iso_pkt) begin
            s_d.iso_rel = 1'b1;
        end
        if (ok && iso_in_token && s_q.iso_pkt) begin
            if (!s_q.iso_deferred_send || s_q.iso_rel) begin
                s_d.iso_send = 1'b1;
                s_d.iso_pkt  = 1'b0;
                s_d.iso_rel  = 1'b0;
            end else begin
                s_d.iso_zlp = 1'b1;
            end
        end

        // Register writes
        if (wr_acc) begin
            case (idx)
                ufi_pkg::IDX_POWER: begin
                    s_d.iso_deferred_send     = pwdata[ufi_pkg::PWR_ISO_DEFER];
                    s_d.controller_inhibit    = s_q.controller_inhibit
                                              & pwdata[ufi_pkg::PWR_INHIBIT];
                    s_d.suspend_detect_enable = pwdata[ufi_pkg::PWR_SUSP_EN];
                    if (pwdata[ufi_pkg::PWR_RESUME] && s_q.suspend_state) begin
                        s_d.resume = 1'b1;
                    end else if (!pwdata[ufi_pkg::PWR_RESUME]) begin
                        s_d.resume = 1'b0;
                    end
                end
                ufi_pkg::IDX_IN_EN:  s_d.in_en  = pwdata[1:0];
                ufi_pkg::IDX_OUT_EN: s_d.out_en = pwdata[1];
                ufi_pkg::IDX_CM_EN:  s_d.cm_en  = pwdata[3:0];
                default: begin
                end
            endcase
        end

        // Soft reset restores every register, inhibit included
        if (wr_power && pwdata[ufi_pkg::PWR_RESET]) begin
            s_d          = ufi_reset_state();
            s_d.core_rst = 1'b1;
            s_d.rdata    = s_q.rdata;
            s_d.slverr   = s_q.slverr;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= ufi_reset_state();
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign pready               = 1'b1;
    assign prdata               = {24'h000000, s_q.rdata};
    assign pslverr              = psel & penable & s_q.slverr;
    assign usb_irq              = |{s_q.in_fl, s_q.out_fl, s_q.cm_fl};
    assign controller_inhibit   = s_q.controller_inhibit;
    assign core_reset           = s_q.core_rst;
    assign drive_resume         = s_q.resume;
    assign suspend_state        = s_q.suspend_state;
    assign iso_send_packet      = s_q.iso_send;
    assign iso_send_zero_length = s_q.iso_zlp;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_inhibit_after_reset: assert property (core_reset |-> controller_inhibit)
        else $error("inhibit not set after soft reset");
    a_inhibit_no_set: assert property (wr_power && !controller_inhibit
        && !pwdata[ufi_pkg::PWR_RESET] |=> !controller_inhibit)
        else $error("software set inhibit");
    // Watches the flops, so a broken traffic gate shows up here
    a_inhibit_blocks: assert property (controller_inhibit && !wr_acc
        |=> (s_q.in_fl & ~$past(s_q.in_fl)) == 2'h0 && !(s_q.out_fl & ~$past(s_q.out_fl))
            && (s_q.cm_fl & ~$past(s_q.cm_fl)) == 4'h0 && $stable(s_q.frame)
            && !iso_send_packet)
        else $error("traffic seen while inhibited");
    a_soft_reset: assert property (wr_power && pwdata[ufi_pkg::PWR_RESET]
        |=> core_reset && usb_irq == 1'b0 ##1 !core_reset)
        else $error("soft reset pulse wrong");
    a_reset_bit_read: assert property (setup && idx == ufi_pkg::IDX_POWER
        |=> prdata[ufi_pkg::PWR_RESET] == $past(sie_bus_reset))
        else $error("reset status bit wrong");
    a_resume_drive: assert property (wr_power && pwdata[ufi_pkg::PWR_RESUME]
        && !pwdata[ufi_pkg::PWR_RESET] && suspend_state |=> drive_resume)
        else $error("resume not driven");
    a_resume_end: assert property (resume_end && s_q.cm_en[ufi_pkg::CM_WAKEUP]
        |=> !suspend_state && usb_irq)
        else $error("resume end did not wake");
    a_suspend_enter: assert property (sleep_det && !sie_resume_detect && !rst_rise
        && !wr_acc |=> suspend_state)
        else $error("suspend not entered");
    a_frame_high: assert property (setup && idx == ufi_pkg::IDX_FRAME_H
        |=> prdata[7:3] == 5'h00 && prdata[2:0] == $past(s_q.frame[10:8]))
        else $error("frame high read wrong");
    a_read_clear: assert property (rd_acc && idx == ufi_pkg::IDX_CM_FL && cm_set == 4'h0
        |=> (s_q.cm_fl & $past(s_q.rdata[3:0])) == 4'h0
            && s_q.in_fl == $past(s_q.in_fl | in_set))
        else $error("read clear wrong");
    a_iso_zero_len: assert property (ok && iso_in_token && s_q.iso_pkt
        && s_q.iso_deferred_send && !s_q.iso_rel |=> iso_send_zero_length
        && !iso_send_packet)
        else $error("deferred iso not zero length");
    a_iso_direct: assert property (ok && iso_in_token && s_q.iso_pkt
        && !s_q.iso_deferred_send |=> iso_send_packet)
        else $error("iso packet not sent");

    c_soft_reset: cover property (wr_power && pwdata[ufi_pkg::PWR_RESET]);
    c_wakeup: cover property (drive_resume ##[1:20] resume_end);
    c_synth_sof: cover property (timer_exp);
    c_iso_defer: cover property (iso_send_zero_length ##[1:50] iso_send_packet);
endmodule

// ===== tb/ufi_sie_model.sv
// Behavioural bus-side engine model feeding the register block's event inputs
`timescale 1ns/1ps
module ufi_sie_model (
    input  wire logic        pclk,
    output logic             sie_sof_token,
    output logic [10:0]      sie_frame_number,
    output logic             sie_bus_reset,
    output logic             sie_resume_detect,
    output logic             sie_suspend_detect,
    output logic             sie_ep0_event,
    output logic             sie_in1_event,
    output logic             sie_out_ep_one_pending_event,
    output logic             iso_in_token
);
    // ------------------------------------------------------------
    // Event lines, one bit each: resume suspend ep0 in1 out_ep_one_pending iso sof
    // ------------------------------------------------------------
    logic [6:0]  ev_q    = 7'h00;
    logic [10:0] frame_q = 11'h7ff;
    logic        rst_q   = 1'b0;

    assign {sie_resume_detect, sie_suspend_detect, sie_ep0_event, sie_in1_event,
            sie_out_ep_one_pending_event, iso_in_token, sie_sof_token} = ev_q;
    assign sie_frame_number = frame_q;
    assign sie_bus_reset    = rst_q;

    // ------------------------------------------------------------
    // Stimulus tasks, all launched just after a rising edge
    // ------------------------------------------------------------
    task automatic pulse(input logic [6:0] m);
        @(posedge pclk);
        ev_q <= m;
        @(posedge pclk);
        ev_q <= 7'h00;
    endtask

    // Frame number only valid with its token; invert it afterwards
    task automatic sof(input logic [10:0] f);
        @(posedge pclk);
        frame_q <= f;
        ev_q    <= 7'h01;
        @(posedge pclk);
        frame_q <= ~f;
        ev_q    <= 7'h00;
    endtask

    task automatic bus_reset(input logic lvl);
        @(posedge pclk);
        rst_q <= lvl;
    endtask
endmodule

// ===== tb/ufi_regs_tb_top.sv
// Self-checking testbench for the USB power, frame and event-flag registers
`timescale 1ns/1ps
module ufi_regs_tb_top;
    localparam logic [6:0] EV_RSM = 7'h40, EV_SUS = 7'h20, EV_EPS = 7'h1c, EV_ISO = 7'h02;
    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic        pkt_rdy;
    logic [31:0] prdata, rdata;
    logic        pready, pslverr, rerr, usb_irq, inhibit, core_reset, drive_resume;
    logic        suspend_state, iso_pkt, iso_zlp, sof, bus_rst, rsm, sus, ep0, in1, out_ep_one_pending, tok;
    logic [10:0] frame;
    int          fail_count = 0, compares = 0, npkt = 0, nzlp = 0, ncore = 0;

    always #50 pclk = ~pclk;
    always @(posedge pclk) begin
        if (iso_pkt === 1'b1) npkt++;
        if (iso_zlp === 1'b1) nzlp++;
        if (core_reset === 1'b1) ncore++;
    end

    ufi_regs #(.FRAME_CYCLES(20), .FRAME_GUARD(2)) ufi_regs_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .sie_sof_token(sof), .sie_frame_number(frame), .sie_bus_reset(bus_rst),
        .sie_resume_detect(rsm), .sie_suspend_detect(sus), .sie_ep0_event(ep0),
        .sie_in1_event(in1), .sie_out_ep_one_pending_event(out_ep_one_pending), .iso_in_token(tok),
        .in_packet_ready(pkt_rdy), .usb_irq(usb_irq), .controller_inhibit(inhibit),
        .core_reset(core_reset), .drive_resume(drive_resume), .suspend_state(suspend_state),
        .iso_send_packet(iso_pkt), .iso_send_zero_length(iso_zlp));

    ufi_sie_model ufi_sie_model_i (
        .pclk(pclk), .sie_sof_token(sof), .sie_frame_number(frame), .sie_bus_reset(bus_rst),
        .sie_resume_detect(rsm), .sie_suspend_detect(sus), .sie_ep0_event(ep0),
        .sie_in1_event(in1), .sie_out_ep_one_pending_event(out_ep_one_pending), .iso_in_token(tok));

    // ------------------------------------------------------------
    // Bus cycle, compare and closing tasks
    // ------------------------------------------------------------
    task automatic tally_and_finish();
        if (fail_count == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Holds the request until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [5:0] idx, input logic [7:0] wd);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {idx, 2'b00};
        pwdata  <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (n == 20) begin
            fail_count++;
            tally_and_finish();
        end
        rdata = prdata;
        rerr  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [5:0] idx, input logic [7:0] exp, input string what);
        apb(1'b0, idx, 8'h00);
        chk(what, {24'h0, exp}, rdata);
    endtask

    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d);
    endtask

    task automatic pkt_ready();
        @(posedge pclk);
        pkt_rdy <= 1'b1;
        @(posedge pclk);
        pkt_rdy <= 1'b0;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        psel    <= 1'b0;
        penable <= 1'b0;
        pwrite  <= 1'b0;
        paddr   <= 8'h00;
        pwdata  <= 32'h00000000;
        pkt_rdy <= 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd(ufi_pkg::IDX_POWER, 8'h10, "power");
        rd(ufi_pkg::IDX_CM_EN, 8'h06, "common enables");
        rd(ufi_pkg::IDX_FRAME_H, 8'h00, "frame high");
        apb(1'b0, 6'h03, 8'h00);
        chk("unmapped data", 32'h0, rdata);
        chk("unmapped error", 32'h1, {31'h0, rerr});
        ufi_sie_model_i.pulse(EV_EPS);
        rd(ufi_pkg::IDX_IN_FL, 8'h00, "inhibited flags");
        wr(ufi_pkg::IDX_POWER, 8'h00);
        wr(ufi_pkg::IDX_POWER, 8'h10);
        rd(ufi_pkg::IDX_POWER, 8'h00, "inhibit set");
        chk("inhibit pin", 32'h0, {31'h0, inhibit});
        ufi_sie_model_i.pulse(EV_EPS);
        repeat (2) @(posedge pclk);
        chk("irq set", 32'h1, {31'h0, usb_irq});
        rd(ufi_pkg::IDX_IN_FL, 8'h03, "in flags");
        rd(ufi_pkg::IDX_IN_FL, 8'h00, "in flags again");
        rd(ufi_pkg::IDX_OUT_FL, 8'h02, "out flags");
        // Clear lands on the access edge, so look one edge later
        @(posedge pclk);
        chk("irq clear", 32'h0, {31'h0, usb_irq});
        wr(ufi_pkg::IDX_CM_EN, 8'h0f);
        ufi_sie_model_i.sof(11'h5a3);
        rd(ufi_pkg::IDX_FRAME_L, 8'ha3, "frame low");
        rd(ufi_pkg::IDX_FRAME_H, 8'h05, "frame high");
        rd(ufi_pkg::IDX_CM_FL, 8'h08, "sof flag");
        repeat (30) @(posedge pclk);
        rd(ufi_pkg::IDX_CM_FL, 8'h08, "synth sof");
        wr(ufi_pkg::IDX_CM_EN, 8'h07);
        apb(1'b0, ufi_pkg::IDX_CM_FL, 8'h00);
        ufi_sie_model_i.bus_reset(1'b1);
        repeat (3) @(posedge pclk);
        rd(ufi_pkg::IDX_POWER, 8'h08, "reset seen");
        ufi_sie_model_i.bus_reset(1'b0);
        rd(ufi_pkg::IDX_POWER, 8'h00, "reset gone");
        rd(ufi_pkg::IDX_CM_FL, 8'h04, "bus reset flag");
        wr(ufi_pkg::IDX_CM_EN, 8'h07);
        ufi_sie_model_i.pulse(EV_SUS);
        rd(ufi_pkg::IDX_CM_FL, 8'h00, "sleep disabled");
        wr(ufi_pkg::IDX_POWER, 8'h01);
        ufi_sie_model_i.pulse(EV_SUS);
        rd(ufi_pkg::IDX_POWER, 8'h03, "suspended");
        chk("suspend pin", 32'h1, {31'h0, suspend_state});
        rd(ufi_pkg::IDX_CM_FL, 8'h01, "sleep flag");
        ufi_sie_model_i.pulse(EV_RSM);
        rd(ufi_pkg::IDX_POWER, 8'h01, "resumed");
        rd(ufi_pkg::IDX_CM_FL, 8'h02, "wakeup flag");
        ufi_sie_model_i.pulse(EV_SUS);
        apb(1'b0, ufi_pkg::IDX_CM_FL, 8'h00);
        wr(ufi_pkg::IDX_POWER, 8'h05);
        repeat (2) @(posedge pclk);
        chk("drive resume", 32'h1, {31'h0, drive_resume});
        // Wakeup length shortened to keep the run brief
        repeat (100) @(posedge pclk);
        wr(ufi_pkg::IDX_POWER, 8'h01);
        repeat (2) @(posedge pclk);
        chk("resume ended", 32'h0, {31'h0, drive_resume});
        rd(ufi_pkg::IDX_POWER, 8'h01, "wakeup done");
        rd(ufi_pkg::IDX_CM_FL, 8'h02, "wakeup irq");
        wr(ufi_pkg::IDX_POWER, 8'h00);
        pkt_ready();
        ufi_sie_model_i.pulse(EV_ISO);
        repeat (2) @(posedge pclk);
        chk("iso direct", 32'h1, npkt);
        wr(ufi_pkg::IDX_POWER, 8'h80);
        pkt_ready();
        ufi_sie_model_i.pulse(EV_ISO);
        repeat (2) @(posedge pclk);
        chk("iso zero length", 32'h1, nzlp);
        chk("iso held", 32'h1, npkt);
        ufi_sie_model_i.sof(11'h001);
        ufi_sie_model_i.pulse(EV_ISO);
        repeat (2) @(posedge pclk);
        chk("iso after sof", 32'h2, npkt);
        wr(ufi_pkg::IDX_POWER, 8'h08);
        repeat (3) @(posedge pclk);
        chk("core reset pulses", 32'h1, ncore);
        rd(ufi_pkg::IDX_POWER, 8'h10, "power soft reset");
        chk("inhibit pin", 32'h1, {31'h0, inhibit});
        rd(ufi_pkg::IDX_CM_EN, 8'h06, "enables soft reset");
        tally_and_finish();
    end
endmodule
